// ---- core/fws_poller.sv ----
// host-side write status poller for a dual-bank async nor flash
// assumes an axi4-lite master on clk and flash pins outside this clock
// Contract
// - select or output strobe delimits each read
// - start polling with two consecutive full reads
// - steady toggle means done, next read array
// - toggling with time-limit: recheck, then reset command
// - resumed monitoring restarts with two fresh reads
// - after time-limit failure host writes reset
// - fast added sectors may skip window check
// - check window bit before and after adding
// - poll reads use a valid program/sector address
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "fws_regs.svh"
module fws_poller
  import fws_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // axi4-lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // flash pins
  output logic flashSelN,
  output logic outputStrobeN,
  output logic writeStrobeN,
  output logic [21:0] flashAddr,
  input wire logic [7:0] dqIn,
  output logic [7:0] dqOut,
  output logic dqOe,
  input wire logic readyBusyN
);
  typedef enum logic [2:0] {
    FWS_IDLE = 3'b000,
    FWS_FIRST = 3'b001,  // first of the two opening reads
    FWS_SECOND = 3'b010, // compare read
    FWS_RECHECK = 3'b011,// recheck after time-limit seen
    FWS_RESET = 3'b100,  // reset command write
    FWS_WIN_PRE = 3'b101,// window check before adding
    FWS_ADD = 3'b110,    // added sector erase write
    FWS_WIN_POST = 3'b111// window check after adding
  } fws_st_t;
  // toggle bit FWS_DQ_PTOG (bit 6) of two status bytes, compared
  function automatic logic toggled(input logic [7:0] a, input logic [7:0] b);
    toggled = (a[`FWS_DQ_PTOG] != b[`FWS_DQ_PTOG]);
  endfunction
  logic rstS1_r, rstS2_r;           // reset release synchroniser
  logic [7:0] dqS1_r, dqS2_r;       // data pin synchroniser
  logic rbS1_r, rbS2_r;             // ready/busy synchroniser
  fws_st_t st_r;
  logic [31:0] ctrl_r;              // op code and go
  logic [21:0] addr_r;              // valid program or sector address
  logic [7:0] wdat_r;               // added-sector command byte
  logic busy_r, done_r, fail_r, reject_r, winPre_r;
  logic [7:0] prev_r;               // last status byte
  logic [7:0] arr_r;                // byte of the last compare, recheck or post-window read
  logic cycStart_r;
  fws_cyc_t cycReq_r;
  logic cycDone;
  logic [7:0] cycData;
  fws_pins_t pins;
  logic awHeld_r, wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic goPulse;
  ////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstS1_r <= 1'b0;
      rstS2_r <= 1'b0;
    end else begin
      rstS1_r <= 1'b1;
      rstS2_r <= rstS1_r;
    end
  end
  always_ff @(posedge clk or negedge rstS2_r) begin
    if (!rstS2_r) begin
      dqS1_r <= 8'h00;
      dqS2_r <= 8'h00;
      rbS1_r <= 1'b1;
      rbS2_r <= 1'b1;
    end else begin
      dqS1_r <= dqIn;
      dqS2_r <= dqS1_r;
      rbS1_r <= readyBusyN;
      rbS2_r <= rbS1_r;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data taken in either order
  assign goPulse = awHeld_r && wHeld_r && !bvalid && (awAddr_r == `FWS_CTRL_OFS)
    && wStrb_r[0] && wData_r[`FWS_CTRL_GO] && !busy_r;
  always_ff @(posedge clk or negedge rstS2_r) begin
    if (!rstS2_r) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else begin
      awready <= !awHeld_r && !awready && !(awvalid && awready);
      wready <= !wHeld_r && !wready && !(wvalid && wready);
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
        wready <= 1'b0;
      end
      if (awHeld_r && wHeld_r && !bvalid) begin
        bvalid <= 1'b1;
        // unmapped or read-only offsets answer slverr
        bresp <= (awAddr_r == `FWS_CTRL_OFS || awAddr_r == `FWS_ADDR_OFS
          || awAddr_r == `FWS_WDATA_OFS) ? 2'b00 : 2'b10;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
      end
    end
  end
  // control registers, writable only while idle
  always_ff @(posedge clk or negedge rstS2_r) begin
    if (!rstS2_r) begin
      ctrl_r <= `FWS_CTRL_RST;
      addr_r <= 22'h00_0000;
      wdat_r <= 8'h00;
    end else if (awHeld_r && wHeld_r && !bvalid && !busy_r && wStrb_r[0]) begin
      if (awAddr_r == `FWS_CTRL_OFS) ctrl_r <= wData_r;
      if (awAddr_r == `FWS_ADDR_OFS) addr_r <= wData_r[21:0];
      if (awAddr_r == `FWS_WDATA_OFS) wdat_r <= wData_r[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////
  // axi4-lite read
  always_ff @(posedge clk or negedge rstS2_r) begin
    if (!rstS2_r) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
    end else begin
      arready <= !rvalid && !arready;
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= 2'b00;
        unique case (araddr)
          `FWS_CTRL_OFS: rdata <= ctrl_r;
          `FWS_ADDR_OFS: rdata <= {10'h000, addr_r};
          `FWS_WDATA_OFS: rdata <= {24'h00_0000, wdat_r};
          `FWS_STAT_OFS: rdata <= {26'h000_0000, rbS2_r, winPre_r, reject_r, fail_r,
            done_r, busy_r};
          `FWS_RDATA_OFS: rdata <= {24'h00_0000, arr_r};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= 2'b10; // unmapped
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // polling state machine
  always_ff @(posedge clk or negedge rstS2_r) begin
    if (!rstS2_r) begin
      st_r <= FWS_IDLE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      reject_r <= 1'b0;
      winPre_r <= 1'b0;
      prev_r <= 8'h00;
      arr_r <= 8'h00;
      cycStart_r <= 1'b0;
      cycReq_r <= '0;
    end else begin
      cycStart_r <= 1'b0;
      unique case (st_r)
        FWS_IDLE: if (goPulse) begin
          busy_r <= 1'b1;
          done_r <= 1'b0;
          fail_r <= 1'b0;
          reject_r <= 1'b0;
          cycStart_r <= 1'b1;
          unique case (fws_op_t'(wData_r[`FWS_CTRL_OP_HI:`FWS_CTRL_OP_LO]))
            FWS_OP_READ: begin
              cycReq_r <= '{wr: 1'b0, addr: addr_r, data: 8'h00};
              st_r <= FWS_SECOND;
              prev_r <= 8'h00;
            end
            FWS_OP_WRITE: begin
              cycReq_r <= '{wr: 1'b1, addr: addr_r, data: wdat_r};
              st_r <= FWS_RESET; // plain write ends like a command write
            end
            FWS_OP_POLL: begin
              // a fresh poll always opens with two reads
              cycReq_r <= '{wr: 1'b0, addr: addr_r, data: 8'h00};
              st_r <= FWS_FIRST;
            end
            FWS_OP_ADDSEC: begin
              cycReq_r <= '{wr: 1'b0, addr: addr_r, data: 8'h00};
              st_r <= FWS_WIN_PRE;
            end
          endcase
        end
        FWS_FIRST: if (cycDone) begin
          prev_r <= cycData;
          cycStart_r <= 1'b1; // next select pulse is a new read
          st_r <= FWS_SECOND;
        end
        FWS_SECOND: if (cycDone) begin
          arr_r <= cycData;
          prev_r <= cycData;
          if (ctrl_r[`FWS_CTRL_OP_HI:`FWS_CTRL_OP_LO] == FWS_OP_READ) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            st_r <= FWS_IDLE;
          end else if (!toggled(prev_r, cycData)) begin
            // steady toggle: operation finished
            busy_r <= 1'b0;
            done_r <= 1'b1;
            st_r <= FWS_IDLE;
          end else begin
            cycStart_r <= 1'b1;
            // time-limit seen: one more compare decides
            st_r <= cycData[`FWS_DQ_TLIM] ? FWS_RECHECK : FWS_SECOND;
          end
        end
        FWS_RECHECK: if (cycDone) begin
          arr_r <= cycData;
          if (!toggled(prev_r, cycData)) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            st_r <= FWS_IDLE;
          end else begin
            fail_r <= 1'b1;
            cycReq_r <= '{wr: 1'b1, addr: addr_r, data: `FWS_RESET_CMD};
            cycStart_r <= 1'b1;
            st_r <= FWS_RESET;
          end
        end
        FWS_RESET: if (cycDone) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          st_r <= FWS_IDLE;
        end
        FWS_WIN_PRE: if (cycDone) begin // window always read, no timing assumed
          winPre_r <= cycData[`FWS_DQ_WIN];
          if (cycData[`FWS_DQ_WIN]) begin
            // window already closed: the command would be ignored
            reject_r <= 1'b1;
            busy_r <= 1'b0;
            done_r <= 1'b1;
            st_r <= FWS_IDLE;
          end else begin
            cycReq_r <= '{wr: 1'b1, addr: addr_r, data: wdat_r};
            cycStart_r <= 1'b1;
            st_r <= FWS_ADD;
          end
        end
        FWS_ADD: if (cycDone) begin
          cycReq_r <= '{wr: 1'b0, addr: addr_r, data: 8'h00};
          cycStart_r <= 1'b1;
          st_r <= FWS_WIN_POST;
        end
        FWS_WIN_POST: if (cycDone) begin
          arr_r <= cycData;
          reject_r <= cycData[`FWS_DQ_WIN]; // high here: may be refused
          busy_r <= 1'b0;
          done_r <= 1'b1;
          st_r <= FWS_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // bus cycle engine
  fws_cycle uCycle (
    .clk(clk),
    .rstB(rstS2_r),
    .start(cycStart_r),
    .req(cycReq_r),
    .done(cycDone),
    .rdData(cycData),
    .dqIn(dqS2_r),
    .pins(pins)
  );
  // pins are already registered inside the engine
  assign flashSelN = pins.selN;
  assign outputStrobeN = pins.oeN;
  assign writeStrobeN = pins.weN;
  assign flashAddr = pins.addr;
  assign dqOut = pins.dqOut;
  assign dqOe = pins.dqOe;
endmodule // fws_poller

// ---- core/fws_regs.svh ----
// register offsets, field positions, reset values and timing counts for the status poller
// assumes inclusion by bare name from the poller modules
`ifndef FWS_REGS_SVH
`define FWS_REGS_SVH
// register byte offsets (one aligned 32-bit word each)
`define FWS_CTRL_OFS 8'h00
`define FWS_ADDR_OFS 8'h04
`define FWS_WDATA_OFS 8'h08
`define FWS_STAT_OFS 8'h0C
`define FWS_RDATA_OFS 8'h10
// control field positions
`define FWS_CTRL_GO 0
`define FWS_CTRL_OP_LO 1
`define FWS_CTRL_OP_HI 2
// status field positions
`define FWS_STAT_BUSY 0
`define FWS_STAT_DONE 1
`define FWS_STAT_FAIL 2
`define FWS_STAT_REJECT 3
`define FWS_STAT_WINDOW 4
`define FWS_STAT_RDY 5
// data bit positions on the flash bus
`define FWS_DQ_ESTOG 2
`define FWS_DQ_WIN 3
`define FWS_DQ_TLIM 5
`define FWS_DQ_PTOG 6
`define FWS_DQ_POLL 7
// reset values
`define FWS_CTRL_RST 32'h0000_0000
`define FWS_ADDR_RST 32'h0000_0000
// strobe timing: each bus phase lasts this long
`define FWS_PHASE_NS 80
`define FWS_CLK_MHZ 250
`define FWS_PHASE_CYC ((`FWS_PHASE_NS * `FWS_CLK_MHZ + 999) / 1000)
// the reset command data byte
`define FWS_RESET_CMD 8'hF0
`endif

// ---- core/fws_pkg.sv ----
// types shared by the status poller modules
// assumes fws_regs.svh holds the numeric constants
package fws_pkg;
  // software operation codes
  typedef enum logic [1:0] {
    FWS_OP_READ = 2'b00,  // plain read
    FWS_OP_WRITE = 2'b01, // single bus write
    FWS_OP_POLL = 2'b10,  // toggle polling until done
    FWS_OP_ADDSEC = 2'b11 // added sector erase with window checks
  } fws_op_t;
  // one strobe-level bus cycle request
  typedef struct packed {
    logic wr;
    logic [21:0] addr;
    logic [7:0] data;
  } fws_cyc_t;
  // flash pin drive bundle
  typedef struct packed {
    logic selN;
    logic oeN;
    logic weN;
    logic [21:0] addr;
    logic [7:0] dqOut;
    logic dqOe;
  } fws_pins_t;
endpackage : fws_pkg

// ---- core/fws_cycle.sv ----
// one asynchronous flash bus cycle: setup, strobe low, strobe high
// assumes synchronised read data arrives on dqIn
`timescale 1ns/100ps
`include "fws_regs.svh"
module fws_cycle
  import fws_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstB,
  // request
  input wire logic start,
  input wire fws_cyc_t req,
  output logic done,
  output logic [7:0] rdData,
  // pins
  input wire logic [7:0] dqIn,
  output fws_pins_t pins
);
  localparam logic [7:0] PHASE = 8'(`FWS_PHASE_CYC);
  typedef enum logic [1:0] {
    FWS_C_IDLE = 2'b00,
    FWS_C_SETUP = 2'b01,
    FWS_C_STROBE = 2'b10,
    FWS_C_HOLD = 2'b11
  } fws_cst_t;
  fws_cst_t st_r;
  logic [7:0] cnt_r;
  fws_cyc_t cur_r;
  ////////////////////////////////////////////////////////////////////
  // phase sequencer; select is pulsed high between cycles so every
  // read is seen as a new one by the toggle logic
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      st_r <= FWS_C_IDLE;
      cnt_r <= 8'h00;
      cur_r <= '0;
      done <= 1'b0;
      rdData <= 8'h00;
    end else begin
      done <= 1'b0;
      unique case (st_r)
        FWS_C_IDLE: if (start) begin
          cur_r <= req;
          cnt_r <= PHASE;
          st_r <= FWS_C_SETUP;
        end
        FWS_C_SETUP: if (cnt_r == 8'h01) begin
          cnt_r <= PHASE;
          st_r <= FWS_C_STROBE;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
        FWS_C_STROBE: if (cnt_r == 8'h01) begin
          cnt_r <= PHASE;
          rdData <= dqIn; // sample before strobe rises
          st_r <= FWS_C_HOLD;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
        FWS_C_HOLD: if (cnt_r == 8'h01) begin
          done <= 1'b1;
          st_r <= FWS_C_IDLE;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////
  // pin drive, registered
  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      pins <= '{selN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: '0, dqOut: '0, dqOe: 1'b0};
    end else begin
      pins.addr <= cur_r.addr;
      pins.dqOut <= cur_r.data;
      pins.selN <= !((st_r == FWS_C_SETUP) || (st_r == FWS_C_STROBE));
      pins.oeN <= !((st_r == FWS_C_STROBE) && !cur_r.wr);
      pins.weN <= !((st_r == FWS_C_STROBE) && cur_r.wr);
      pins.dqOe <= cur_r.wr && (st_r != FWS_C_IDLE);
    end
  end
endmodule // fws_cycle

// ---- verification/fws_flash_model.sv ----
// flash device model: status bits on busy-bank reads, array data elsewhere
// assumes the bench loads the embedded operation through load, mode and reads
`timescale 1ns/100ps
module fws_flash_model (
  // host pins
  input wire logic flashSelN,
  input wire logic outputStrobeN,
  input wire logic writeStrobeN,
  input wire logic [21:0] flashAddr,
  input wire logic [7:0] dqOut,
  input wire logic dqOe,
  // bench control: mode 0 idle, 1 program, 2 erase, 3 timing limit
  input wire logic load,
  input wire logic [1:0] mode,
  input wire logic [3:0] reads,
  input wire logic winClosed,
  // device side
  output logic [7:0] dqIn,
  output logic readyBusyN,
  output logic [7:0] lastWr,
  output int wrCnt
);
  logic busy = 1'b0;
  logic tog6 = 1'b0;
  logic tog2 = 1'b0;
  logic tlim = 1'b0;
  logic [3:0] left = 4'h0;
  logic [7:0] last = 8'h00;
  // either strobe opens a fresh read
  wire rdEn = !flashSelN && !outputStrobeN && !dqOe;
  initial begin
    dqIn = 8'hFF;
    lastWr = 8'h00;
    wrCnt = 0;
  end
  assign readyBusyN = !busy;
  // operation starts on the rising edge of load
  always @(posedge load) begin
    busy = mode != 2'b00;
    left = reads;
    tlim = 1'b0;
  end
  // only the busy bank (bank 0) reports status
  always @(posedge rdEn) begin
    if (busy && !flashAddr[21]) begin
      tog6 = !tog6;
      if (mode == 2'b10) tog2 = !tog2;
      if (mode == 2'b11) tlim = 1'b1;
      else if (left == 4'h0) busy = 1'b0;
      else left = left - 4'h1;
    end
    // window bit on bit 3, erase-sector toggle on bit 2
    if (busy && !flashAddr[21])
      last = {mode == 2'b10 ? 1'b0 : ~lastWr[7], tog6, tlim, 1'b0,
        winClosed, tog2, 2'b00};
    else last = flashAddr[7:0] ^ 8'h5A;
    dqIn = last;
  end
  // released bus shows the inverse, never a stale match
  always @(negedge rdEn) dqIn = ~last;
  // writes; while busy, a closed window keeps them out of wrCnt
  // select rises at the same edge as the strobe, so key on the data drive instead
  always @(posedge writeStrobeN) if (dqOe === 1'b1) begin
    if (!(busy && winClosed)) wrCnt = wrCnt + 1;
    lastWr = dqOut;
    if (dqOut == 8'hF0) begin
      busy = 1'b0;
      tlim = 1'b0;
    end
  end
endmodule // fws_flash_model

// ---- verification/fws_poller_checker.sv ----
// checker on the poller ports: flash strobe framing and axi answers
// assumes binding onto fws_poller
`timescale 1ns/100ps
module fws_poller_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // axi
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [1:0] rresp,
  input wire logic [31:0] rdata,
  // flash
  input wire logic flashSelN,
  input wire logic outputStrobeN,
  input wire logic writeStrobeN,
  input wire logic [21:0] flashAddr,
  input wire logic [7:0] dqOut,
  input wire logic dqOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a read opens under select and keeps the strobe down
  sequence rdOpen; $fell(outputStrobeN) && !flashSelN; endsequence
  sequence rdHeld; !outputStrobeN [*8]; endsequence
  rd_framed_a: assert property (rdOpen |-> rdHeld) else $error("read strobe short");
  rd_bus_a: assert property (!outputStrobeN |-> writeStrobeN && !dqOe)
    else $error("read clash");
  sel_release_a: assert property ($rose(outputStrobeN) |-> flashSelN [*8])
    else $error("select held");
  addr_hold_a: assert property (!outputStrobeN && !$past(outputStrobeN) |->
    $stable(flashAddr)) else $error("address moved");
  wr_drive_a: assert property (!writeStrobeN |-> dqOe && outputStrobeN && !flashSelN)
    else $error("write not driven");
  wr_data_a: assert property ($rose(writeStrobeN) |-> $past(dqOe) && $stable(dqOut))
    else $error("write data moved");
  wr_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("no write response");
  rd_resp_a: assert property (arvalid && arready |=> rvalid) else $error("no read response");
  rd_err_a: assert property (rvalid && rresp != 2'b00 |-> rdata == 32'h0000_0000)
    else $error("error read data");
endmodule // fws_poller_checker
bind fws_poller fws_poller_checker chk_u (.clk, .rst_b, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .arvalid, .arready, .rvalid, .rresp, .rdata, .flashSelN, .outputStrobeN,
  .writeStrobeN, .flashAddr, .dqOut, .dqOe);

// ---- verification/tb.sv ----
// testbench: axi4-lite scenarios against the poller and a flash model
// assumes fws_flash_model answers on the flash pins
`timescale 1ns/100ps
`include "fws_regs.svh"
module tb
  import fws_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd, st;
  logic flashSelN, outputStrobeN, writeStrobeN, dqOe, readyBusyN;
  logic [21:0] flashAddr;
  logic [7:0] dqOut, dqIn, lastWr;
  int wrCnt, c;
  // model control
  logic load = 1'b0;
  logic winClosed = 1'b0;
  logic [1:0] mode = 2'b00;
  logic [3:0] reads = 4'h0;
  int mismatches = 0;
  int comparisons = 0;
  always #2 clk = ~clk;
  fws_poller dut_u (.clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .flashSelN, .outputStrobeN, .writeStrobeN, .flashAddr, .dqIn, .dqOut, .dqOe, .readyBusyN);
  fws_flash_model flash_u (.flashSelN, .outputStrobeN, .writeStrobeN, .flashAddr, .dqOut, .dqOe,
    .load, .mode, .reads, .winClosed, .dqIn, .readyBusyN, .lastWr, .wrCnt);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  // write: both channels offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge clk);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // start one operation and wait till busy drops
  task automatic go(input fws_op_t o, input logic [21:0] a);
    axw(`FWS_ADDR_OFS, {10'h000, a});
    axw(`FWS_CTRL_OFS, {29'h0000_0000, o, 1'b1});
    do axr(`FWS_STAT_OFS, st); while (st[`FWS_STAT_BUSY]);
  endtask
  task automatic ld(input logic [1:0] m, input logic [3:0] n);
    mode <= m;
    reads <= n;
    @(posedge clk);
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    axr(`FWS_CTRL_OFS, rd);
    chk(rd, `FWS_CTRL_RST);
    axr(`FWS_ADDR_OFS, rd);
    chk(rd, `FWS_ADDR_RST);
    axr(8'h14, rd);
    chk({rd[29:0], rs}, 32'h0000_0002);
    axw(8'h20, 32'h0000_0001);
    chk({30'h0000_0000, rs}, 32'h0000_0002);
    axw(`FWS_ADDR_OFS, 32'hFFFF_FFFF);
    axr(`FWS_ADDR_OFS, rd);
    chk(rd, 32'h003F_FFFF);
  endtask
  task automatic t_read;
    go(FWS_OP_READ, 22'h20_0034);
    chk(st & 32'h0000_0026, 32'h0000_0022);
    axr(`FWS_RDATA_OFS, rd);
    chk(rd, 32'h0000_006E);
  endtask
  task automatic t_prog;
    axw(`FWS_WDATA_OFS, 32'h0000_0080);
    go(FWS_OP_WRITE, 22'h00_0010);
    chk({24'h00_0000, lastWr}, 32'h0000_0080);
    ld(2'b01, 4'h4);
    axr(`FWS_STAT_OFS, rd);
    chk(rd[`FWS_STAT_RDY], 1'b0);
    go(FWS_OP_POLL, 22'h00_0010);
    chk(st & 32'h0000_0026, 32'h0000_0022);
  endtask
  task automatic t_bank;
    ld(2'b10, 4'h6);
    go(FWS_OP_POLL, 22'h20_0100);
    chk(st & 32'h0000_0026, 32'h0000_0002);
    go(FWS_OP_POLL, 22'h00_0100);
    chk(st & 32'h0000_0026, 32'h0000_0022);
  endtask
  task automatic t_fail;
    ld(2'b11, 4'h0);
    go(FWS_OP_POLL, 22'h00_0200);
    // a failed poll still ends as done, with the fail flag beside it
    chk(st & 32'h0000_0026, 32'h0000_0026);
    chk({24'h00_0000, lastWr}, 32'h0000_00F0);
    // last status byte kept must show the time-limit bit
    axr(`FWS_RDATA_OFS, rd);
    chk(rd & 32'h0000_0020, 32'h0000_0020);
  endtask
  task automatic t_addsec;
    ld(2'b10, 4'hF);
    axw(`FWS_WDATA_OFS, 32'h0000_0030);
    c = wrCnt;
    go(FWS_OP_ADDSEC, 22'h00_2000);
    chk(st & 32'h0000_0018, 32'h0000_0000);
    chk(wrCnt, c + 1);
    winClosed <= 1'b1;
    go(FWS_OP_ADDSEC, 22'h00_3000);
    chk(st & 32'h0000_0018, 32'h0000_0018);
    chk(wrCnt, c + 1);
    winClosed <= 1'b0;
    axw(`FWS_WDATA_OFS, 32'h0000_00F0);
    go(FWS_OP_WRITE, 22'h00_0000);
    chk(st[`FWS_STAT_RDY], 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_read();
    t_prog();
    t_bank();
    t_fail();
    t_addsec();
    test_done();
  end
  // watchdog: the run needs a few thousand cycles
  initial begin
    #200000;
    mismatches = mismatches + 1;
    test_done();
  end
endmodule // tb
